//--- verilog/lcsp_defs.vh
`ifndef LCSP_DEFS_VH
`define LCSP_DEFS_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define LCSP_IDX_LINE_PTR 10'h00C
`define LCSP_IDX_LINK_PTR 10'h00E
`define LCSP_IDX_CMD      10'h010
`define LCSP_IDX_WR       10'h011
`define LCSP_IDX_RD       10'h012
`define LCSP_IDX_CTRL     10'h013
`define LCSP_IDX_STATUS   10'h014

// ==========================================================
// Control register fields
`define LCSP_CTRL_BCAST   7
`define LCSP_CTRL_FRAMED  6
`define LCSP_CTRL_CHKEN   5
`define LCSP_CTRL_GO      4
`define LCSP_CTRL_CH_HI   1
`define LCSP_CTRL_CH_LO   0

// ==========================================================
// Status register fields
`define LCSP_STAT_BUSY    0
`define LCSP_STAT_LOCK    1
`define LCSP_STAT_PORT    2
`define LCSP_STAT_MON     3

// ==========================================================
// Reset values
`define LCSP_RST_BYTE     8'h00
`define LCSP_RST_SEED     15'h7FFF

// ==========================================================
// Timing counts
`define LCSP_SCLK_HALF    4'h4
`define LCSP_XFER_BITS    5'h18
`define LCSP_RD_FIRST     5'h10
`define LCSP_LOCK_RUN     6'h20
`define LCSP_LOSS_ERRS    4'h8
`define LCSP_GOOD_CLEAR   7'h40
`endif

//--- verilog/lcsp_top.v
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`include "lcsp_defs.vh"

module lcsp_top
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [3:0]  line_event_ch,
  input  wire [3:0]  link_event_ch,
  input  wire        strap_ctrl_port_sel,
  input  wire        strap_monitor_sel,
  output reg  [3:0]  xcvr_select_n,
  output reg         xcvr_serial_clk,
  output reg         ctrl_serial_out,
  input  wire        ctrl_serial_in,
  input  wire        tx_pattern_src_clk,
  input  wire        tx_frame_slot,
  output reg         tx_pattern_data,
  input  wire        recovered_line_clk,
  input  wire        recv_line_clk,
  input  wire        rx_slip_buf_en,
  input  wire [3:0]  rx_highway_data,
  input  wire        rx_frame_slot,
  output reg         pattern_sync_lost
);

  // ==========================================================
  // Pin synchronisers
  reg  [9:0] sync_a;
  reg  [9:0] sync_b;
  wire [9:0] pin_raw;
  assign pin_raw = {rx_frame_slot, rx_highway_data, recv_line_clk, recovered_line_clk,
                    tx_frame_slot, tx_pattern_src_clk, ctrl_serial_in};

  // Two flops per pin, first flop read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1)
    begin : g_sync
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end
        else
        begin
          sync_a[gi] <= pin_raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  reg       strap_port_a;
  reg       strap_port_b;
  reg       strap_mon_a;
  reg       strap_mon_b;

  // Straps follow the same two-flop path
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_port_a <= 1'b1;
      strap_port_b <= 1'b1;
      strap_mon_a  <= 1'b1;
      strap_mon_b  <= 1'b1;
    end
    else
    begin
      strap_port_a <= strap_ctrl_port_sel;
      strap_port_b <= strap_port_a;
      strap_mon_a  <= strap_monitor_sel;
      strap_mon_b  <= strap_mon_a;
    end
  end

  wire       sdi_s     = sync_b[0];
  wire       txclk_s   = sync_b[1];
  wire       txslot_s  = sync_b[2];
  wire       rclk_s    = sync_b[3];
  wire       lrclk_s   = sync_b[4];
  wire [3:0] rxdata_s  = sync_b[8:5];
  wire       rxslot_s  = sync_b[9];
  wire       port_on   = ~strap_port_b;
  wire       xmit_mode = ~strap_mon_b;

  // ==========================================================
  // Registers
  reg  [7:0] xcvr_cmd_bits;
  reg  [7:0] xcvr_wr_bits;
  reg  [7:0] xcvr_rd_bits;
  reg  [7:0] ctrl_reg;
  reg  [3:0] line_event_channel_ptr;
  reg  [3:0] link_event_channel_ptr;
  reg        busy;
  reg        locked;

  // Word index decode, also used for the unmapped check
  function [2:0] lcsp_decode;
    input [11:0] addr;
    begin
      lcsp_decode = 3'h7;
      if (addr[1:0] == 2'h0)
      begin
        case (addr[11:2])
          `LCSP_IDX_LINE_PTR: lcsp_decode = 3'h0;
          `LCSP_IDX_LINK_PTR: lcsp_decode = 3'h1;
          `LCSP_IDX_CMD:      lcsp_decode = 3'h2;
          `LCSP_IDX_WR:       lcsp_decode = 3'h3;
          `LCSP_IDX_RD:       lcsp_decode = 3'h4;
          `LCSP_IDX_CTRL:     lcsp_decode = 3'h5;
          `LCSP_IDX_STATUS:   lcsp_decode = 3'h6;
          default:            lcsp_decode = 3'h7;
        endcase
      end
    end
  endfunction

  wire [2:0] sel_reg   = lcsp_decode(paddr);
  wire       acc_cycle = psel & penable;
  wire       wr_take   = acc_cycle & pready & pwrite;

  reg  [7:0] next_rdata;
  // Read mux; pointer upper nibbles read zero
  always @*
  begin
    next_rdata = 8'h00;
    case (sel_reg)
      3'h0: next_rdata = {4'h0, line_event_channel_ptr};
      3'h1: next_rdata = {4'h0, link_event_channel_ptr};
      3'h2: next_rdata = xcvr_cmd_bits;
      3'h3: next_rdata = xcvr_wr_bits;
      3'h4: next_rdata = xcvr_rd_bits;
      3'h5: next_rdata = ctrl_reg;
      3'h6: next_rdata = {4'h0, strap_mon_b, port_on, locked, busy};
      default: next_rdata = 8'h00;
    endcase
  end

  // APB: one wait state, data and error registered with pready
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= acc_cycle & ~pready;
      pslverr <= acc_cycle & ~pready & (sel_reg == 3'h7 || (pwrite && (sel_reg == 3'h0 ||
                 sel_reg == 3'h1 || sel_reg == 3'h4 || sel_reg == 3'h6)));
      if (acc_cycle && !pready && !pwrite)
        prdata <= {24'h000000, next_rdata};
    end
  end

  // Pointer capture from framer event latches
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_event_channel_ptr <= 4'h0;
      link_event_channel_ptr <= 4'h0;
    end
    else
    begin
      line_event_channel_ptr <= line_event_ch;
      link_event_channel_ptr <= link_event_ch;
    end
  end

  // Writable registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xcvr_cmd_bits <= `LCSP_RST_BYTE;
      xcvr_wr_bits  <= `LCSP_RST_BYTE;
      ctrl_reg      <= `LCSP_RST_BYTE;
    end
    else if (wr_take)
    begin
      if (sel_reg == 3'h2)
        xcvr_cmd_bits <= pwdata[7:0];
      if (sel_reg == 3'h3)
        xcvr_wr_bits <= pwdata[7:0];
      if (sel_reg == 3'h5)
        ctrl_reg <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Serial control port
  localparam ST_IDLE  = 1'b0;
  localparam ST_SHIFT = 1'b1;

  reg        go_prev;
  reg [15:0] out_shift;
  reg  [4:0] bit_cnt;
  reg  [3:0] half_cnt;
  // Go edge counts only on a 0 to 1 change, so a held 1 never retriggers
  // rearm by clearing
  wire go_rise  = ctrl_reg[`LCSP_CTRL_GO] & ~go_prev;
  wire start    = go_rise & port_on & xmit_mode & ~busy;
  wire half_end = (half_cnt == `LCSP_SCLK_HALF - 4'h1);
  wire last_bit = (bit_cnt == `LCSP_XFER_BITS - 5'h01);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      go_prev         <= 1'b0;
      busy            <= ST_IDLE;
      out_shift       <= 16'h0000;
      bit_cnt         <= 5'h00;
      half_cnt        <= 4'h0;
      xcvr_select_n   <= 4'hF;
      xcvr_serial_clk <= 1'b0;
      ctrl_serial_out <= 1'b0;
      xcvr_rd_bits    <= `LCSP_RST_BYTE;
    end
    else
    begin
      go_prev <= ctrl_reg[`LCSP_CTRL_GO];
      case (busy)
        ST_IDLE:
        begin
          if (start)
          begin
            busy      <= ST_SHIFT;
            bit_cnt   <= 5'h00;
            half_cnt  <= 4'h0;
            ctrl_serial_out <= xcvr_cmd_bits[0];
            // Data byte sits right behind command bit 7, pad bit on top
            out_shift <= {1'b0, xcvr_wr_bits, xcvr_cmd_bits[7:1]};
            if (ctrl_reg[`LCSP_CTRL_BCAST])
              xcvr_select_n <= 4'h0;
            else
              xcvr_select_n <= ~(4'h1 << ctrl_reg[`LCSP_CTRL_CH_HI:`LCSP_CTRL_CH_LO]);
          end
        end
        ST_SHIFT:
        begin
          half_cnt <= half_end ? 4'h0 : half_cnt + 4'h1;
          if (half_end && !xcvr_serial_clk)
          begin
            xcvr_serial_clk <= 1'b1;
            if (bit_cnt >= `LCSP_RD_FIRST)
              xcvr_rd_bits <= {sdi_s, xcvr_rd_bits[7:1]};
          end
          else if (half_end)
          begin
            xcvr_serial_clk <= 1'b0;
            if (last_bit)
            begin
              busy            <= ST_IDLE;
              xcvr_select_n   <= 4'hF;
              ctrl_serial_out <= 1'b0;
            end
            else
            begin
              bit_cnt <= bit_cnt + 5'h01;
              ctrl_serial_out <= (bit_cnt < `LCSP_RD_FIRST - 5'h01) ? out_shift[0] : 1'b0;
              out_shift <= {1'b0, out_shift[15:1]};
            end
          end
        end
        default: busy <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Pattern generator, x^15 + x^14 + 1
  reg [14:0] gen_lfsr;
  reg        txclk_prev;
  wire tx_step = txclk_s & ~txclk_prev;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txclk_prev      <= 1'b0;
      gen_lfsr        <= `LCSP_RST_SEED;
      tx_pattern_data <= 1'b0;
    end
    else
    begin
      txclk_prev <= txclk_s;
      if (tx_step)
      begin
        if (ctrl_reg[`LCSP_CTRL_FRAMED] && txslot_s)
          tx_pattern_data <= 1'b0;
        else
        begin
          tx_pattern_data <= gen_lfsr[14] ^ gen_lfsr[13];
          gen_lfsr        <= {gen_lfsr[13:0], gen_lfsr[14] ^ gen_lfsr[13]};
        end
      end
    end
  end

  // ==========================================================
  // Pattern analyzer, self-synchronising
  reg [14:0] chk_lfsr;
  reg        rclk_prev;
  reg  [5:0] run_cnt;
  reg  [3:0] err_cnt;
  reg  [6:0] good_cnt;
  wire rclk_sel = rx_slip_buf_en ? lrclk_s : rclk_s;
  wire rx_bit   = rxdata_s[ctrl_reg[`LCSP_CTRL_CH_HI:`LCSP_CTRL_CH_LO]];
  wire chk_on   = ctrl_reg[`LCSP_CTRL_CHKEN] & xmit_mode;
  wire rx_step  = (rclk_sel & ~rclk_prev) & ~(ctrl_reg[`LCSP_CTRL_FRAMED] & rxslot_s);
  wire match    = (rx_bit == (chk_lfsr[14] ^ chk_lfsr[13]));

  // Errors are counted, not single-shot, so one hit does not drop lock
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rclk_prev <= 1'b0;
      chk_lfsr  <= 15'h0000;
      run_cnt   <= 6'h00;
      err_cnt   <= 4'h0;
      good_cnt  <= 7'h00;
      locked    <= 1'b0;
    end
    else
    begin
      rclk_prev <= rclk_sel;
      if (!chk_on)
      begin
        run_cnt  <= 6'h00;
        err_cnt  <= 4'h0;
        good_cnt <= 7'h00;
        locked   <= 1'b0;
      end
      else if (rx_step)
      begin
        chk_lfsr <= {chk_lfsr[13:0], rx_bit};
        if (!locked)
        begin
          run_cnt <= match ? run_cnt + 6'h01 : 6'h00;
          if (match && run_cnt == `LCSP_LOCK_RUN - 6'h01)
          begin
            locked   <= 1'b1;
            err_cnt  <= 4'h0;
            good_cnt <= 7'h00;
          end
        end
        else if (!match)
        begin
          good_cnt <= 7'h00;
          err_cnt  <= err_cnt + 4'h1;
          if (err_cnt == `LCSP_LOSS_ERRS - 4'h1)
          begin
            locked  <= 1'b0;
            run_cnt <= 6'h00;
          end
        end
        else
        begin
          good_cnt <= good_cnt + 7'h01;
          if (good_cnt == `LCSP_GOOD_CLEAR - 7'h01)
            err_cnt <= 4'h0;
        end
      end
    end
  end

  // Sync-lost pin from its own flop
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pattern_sync_lost <= 1'b1;
    else
      pattern_sync_lost <= ~locked;
  end

endmodule

//--- test/lcsp_top_props.sv
`timescale 1ns/100ps
// ============================================================
// Port checks: register bus answer, serial control port and sync-lost pin
module lcsp_top_props
(
  input wire       pclk,
  input wire       presetn,
  input wire       psel,
  input wire       penable,
  input wire       pready,
  input wire       pslverr,
  input wire       strap_ctrl_port_sel,
  input wire       strap_monitor_sel,
  input wire [3:0] xcvr_select_n,
  input wire       xcvr_serial_clk,
  input wire       ctrl_serial_out,
  input wire       pattern_sync_lost
);
  logic [7:0] low_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Select-low run length; too long for a repetition operator
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      low_cnt <= 8'h00;
    else
      low_cnt <= (xcvr_select_n != 4'hF) ? low_cnt + 8'h01 : 8'h00;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  property p_apb_ans;
    s_setup ##1 s_access |=> pready ##1 !pready;
  endproperty
  a_apb_ans: assert property (p_apb_ans) else $error("pready late or long");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  // Straps are synchronised, so they must be steady a few cycles first
  property p_port_off;
    strap_ctrl_port_sel [*5] ##0 (xcvr_select_n == 4'hF) |=> xcvr_select_n == 4'hF;
  endproperty
  a_port_off: assert property (p_port_off) else $error("select with port off");
  property p_mon_off;
    strap_monitor_sel [*5] ##0 (xcvr_select_n == 4'hF) |=> xcvr_select_n == 4'hF;
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("select in monitor mode");
  property p_sync_mon;
    strap_monitor_sel [*6] |-> pattern_sync_lost;
  endproperty
  a_sync_mon: assert property (p_sync_mon) else $error("lock shown in monitor mode");
  property p_sel_len;
    (low_cnt != 8'h00) |-> ((xcvr_select_n == 4'hF) ? (low_cnt == 8'hC0) : (low_cnt < 8'hC0));
  endproperty
  a_sel_len: assert property (p_sel_len) else $error("select low length wrong");
  property p_sel_hold;
    (xcvr_select_n != 4'hF && low_cnt != 8'h00) |-> $stable(xcvr_select_n);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select changed mid transfer");
  property p_sel_shape;
    xcvr_select_n inside {4'hF, 4'hE, 4'hD, 4'hB, 4'h7, 4'h0};
  endproperty
  a_sel_shape: assert property (p_sel_shape) else $error("select pattern illegal");
  property p_sclk;
    $rose(xcvr_serial_clk) |-> xcvr_serial_clk [*4] ##1 !xcvr_serial_clk [*4];
  endproperty
  a_sclk: assert property (p_sclk) else $error("serial clock period wrong");
  property p_sclk_idle;
    (xcvr_select_n == 4'hF) |-> !xcvr_serial_clk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock while idle");
  property p_out_edge;
    $changed(ctrl_serial_out) |-> $fell(xcvr_serial_clk) || $past(xcvr_select_n) == 4'hF;
  endproperty
  a_out_edge: assert property (p_out_edge) else $error("serial out moved off edge");
endmodule
bind lcsp_top lcsp_top_props u_props (.*);

//--- test/lcsp_xcvr_model.sv
`timescale 1ns/100ps
// ============================================================
// Transceiver seen across the serial control port
module lcsp_xcvr_model
(
  input  wire       pclk,
  input  wire [3:0] xcvr_select_n,
  input  wire       xcvr_serial_clk,
  input  wire       ctrl_serial_out,
  input  wire       slow,
  output wire       ctrl_serial_in,
  output wire [7:0] got_cmd,
  output wire [7:0] got_data
);
  logic [15:0] rx_sh = 16'h0000;
  logic [4:0]  n = 5'h00;
  logic        drv = 1'h0;
  logic        late = 1'h0;
  logic        tog = 1'h0;
  wire         sel = (xcvr_select_n != 4'hF);
  assign got_cmd = rx_sh[7:0];
  assign got_data = rx_sh[15:8];
  // Released line toggles, so a stale bit is never mistaken for data
  assign ctrl_serial_in = !sel ? tog : (slow ? late : drv);
  // Each frame restarts the bit count
  always @(posedge sel)
    n <= 5'h00;
  // Command then data, taken on the rise, first bit ends lowest
  always @(posedge xcvr_serial_clk)
  begin
    if (n < 5'h10)
      rx_sh <= {ctrl_serial_out, rx_sh[15:1]};
    n <= n + 5'h01;
  end
  // Reply is the inverted command, sent on the fall, LSB first
  always @(negedge xcvr_serial_clk)
    if (n >= 5'h10 && n < 5'h18)
      drv <= ~rx_sh[n - 5'h10];
  // Slow answer lags one cycle
  always @(posedge pclk)
  begin
    late <= drv;
    tog <= ~tog;
  end
endmodule

//--- test/line_ctrl_serial_and_prbs_tb.sv
`timescale 1ns/100ps
`include "lcsp_defs.vh"
module line_ctrl_serial_and_prbs_tb;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  line_event_ch = 4'h0;
  logic [3:0]  link_event_ch = 4'h0;
  logic        strap_ctrl_port_sel = 1'h0;
  logic        strap_monitor_sel = 1'h0;
  logic        rx_slip_buf_en = 1'h0;
  logic        slow = 1'h0;
  logic        brk = 1'h0;
  logic [8:0]  pc = 9'h000;
  logic [15:0] rnd = 16'h0063;
  logic [31:0] rv, prdata;
  logic        ev, pready, pslverr, xcvr_serial_clk, ctrl_serial_out, ctrl_serial_in;
  logic        tx_pattern_data, pattern_sync_lost;
  logic [3:0]  xcvr_select_n;
  logic [7:0]  got_cmd, got_data;
  logic [9:0]  rw_idx [3] = '{`LCSP_IDX_CMD, `LCSP_IDX_WR, `LCSP_IDX_CTRL};
  int          failures = 0;
  int          checks_done = 0;
  // Pattern clocks; the unused analyzer clock stands still
  wire         tx_pattern_src_clk = pc[3]; // source in phase with bench clock
  wire         recovered_line_clk = ~pc[3] & ~rx_slip_buf_en;
  wire         recv_line_clk = ~pc[3] & rx_slip_buf_en;
  wire         tx_frame_slot = (pc[8:4] == 5'h00);
  // Receive slot lags by one source period, where the slot bit reaches the analyzer
  wire         rx_frame_slot = (pc[8:4] == 5'h01);
  wire [3:0]   rx_highway_data = {4{tx_pattern_data ^ brk}};
  lcsp_top DUT (.*);
  lcsp_xcvr_model u_xcvr (.pclk(pclk), .xcvr_select_n(xcvr_select_n), .xcvr_serial_clk(xcvr_serial_clk),
    .ctrl_serial_out(ctrl_serial_out), .slow(slow), .ctrl_serial_in(ctrl_serial_in), .got_cmd(got_cmd),
    .got_data(got_data));
  // ============================================================
  // Clocks and helpers
  always #2.5 pclk = ~pclk;
  always @(posedge pclk)
    pc <= pc + 9'h001;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[14] ^ s[12] ^ s[3]};
  endfunction
  task close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'h1 && k < 20);
    rv = prdata;
    ev = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (k >= 20)
    begin
      failures++;
      close_out;
    end
  endtask
  // Bounded wait on select (pick 0) or sync-lost (pick 1)
  task automatic wait_on(input logic [3:0] e, input logic pick, input int n);
    int k;
    for (k = 0; k < n && (pick ? {3'h0, pattern_sync_lost} : xcvr_select_n) !== e; k++)
      @(posedge pclk);
    chk(pick ? {3'h0, pattern_sync_lost} : xcvr_select_n, e);
    if (k >= n)
      close_out;
  endtask
  task automatic quiet(input int n);
    logic [3:0] s;
    s = 4'hF;
    repeat (n)
    begin
      @(posedge pclk);
      s = s & xcvr_select_n;
    end
    chk(s, 4'hF);
  endtask
  task automatic xfer(input logic [1:0] ch, input logic bc);
    logic [7:0] c;
    logic [7:0] d;
    rnd = lfsr(rnd);
    c = rnd[7:0];
    d = rnd[15:8];
    apb(1'h1, `LCSP_IDX_CMD, c);
    apb(1'h1, `LCSP_IDX_WR, d);
    apb(1'h1, `LCSP_IDX_CTRL, {bc, 5'h00, ch}); // clear go before set
    apb(1'h1, `LCSP_IDX_CTRL, {bc, 2'h0, 1'h1, 2'h0, ch});
    wait_on(bc ? 4'h0 : ~(4'h1 << ch), 1'h0, 10); // chosen select
    wait_on(4'hF, 1'h0, 250); // released
    chk(got_cmd, c); // command first
    chk(got_data, d); // data second
    apb(1'h0, `LCSP_IDX_RD, 8'h00);
    if (!bc)
      chk(rv, {24'h0, ~c}); // read-back
  endtask
  // ============================================================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    foreach (rw_idx[i])
    begin
      apb(1'h0, rw_idx[i], 8'h00);
      chk(rv, 32'h0); // reset zero
      rnd = lfsr(rnd);
      apb(1'h1, rw_idx[i], rnd[7:0] & 8'hEF);
      apb(1'h0, rw_idx[i], 8'h00);
      chk(rv, {24'h0, rnd[7:0] & 8'hEF}); // read/write
    end
    apb(1'h0, 10'h3FF, 8'h00);
    chk(ev, 1'h1);
    apb(1'h1, `LCSP_IDX_RD, 8'h5A);
    chk(ev, 1'h1); // read only
    repeat (3)
    begin
      rnd = lfsr(rnd);
      line_event_ch <= rnd[3:0];
      link_event_ch <= rnd[7:4];
      apb(1'h0, `LCSP_IDX_LINE_PTR, 8'h00);
      chk(rv & 32'hF, rnd[3:0]); // line pointer
      apb(1'h0, `LCSP_IDX_LINK_PTR, 8'h00);
      chk(rv & 32'hF, rnd[7:4]); // link pointer
    end
    $display("test registers done");
    for (int c = 0; c < 4; c++)
    begin
      slow <= c[0];
      xfer(c[1:0], 1'h0);
    end
    xfer(2'h3, 1'h1);
    apb(1'h1, `LCSP_IDX_CTRL, 8'h01);
    apb(1'h1, `LCSP_IDX_CTRL, 8'h11);
    wait_on(4'hD, 1'h0, 10);
    apb(1'h1, `LCSP_IDX_CTRL, 8'h01);
    apb(1'h1, `LCSP_IDX_CTRL, 8'h11);
    wait_on(4'hF, 1'h0, 250);
    quiet(40); // start lost while busy
    apb(1'h1, `LCSP_IDX_CTRL, 8'h11);
    quiet(40); // no rearm
    strap_ctrl_port_sel <= 1'h1;
    apb(1'h1, `LCSP_IDX_CTRL, 8'h00);
    apb(1'h1, `LCSP_IDX_CTRL, 8'h10);
    quiet(40); // port disabled
    strap_ctrl_port_sel <= 1'h0;
    strap_monitor_sel <= 1'h1;
    apb(1'h1, `LCSP_IDX_CTRL, 8'h80);
    apb(1'h1, `LCSP_IDX_CTRL, 8'h90);
    quiet(40); // monitor mode
    strap_monitor_sel <= 1'h0;
    $display("test serial port done");
    chk(pattern_sync_lost, 1'h1); // disabled unlocked
    apb(1'h1, `LCSP_IDX_CTRL, 8'h20);
    wait_on(4'h0, 1'h1, 6000); // unframed lock
    brk <= 1'h1;
    wait_on(4'h1, 1'h1, 1000); // unlocked on errors
    brk <= 1'h0;
    rx_slip_buf_en <= 1'h1;
    apb(1'h1, `LCSP_IDX_CTRL, 8'h62);
    wait_on(4'h0, 1'h1, 6000); // framed slip clock
    strap_monitor_sel <= 1'h1;
    wait_on(4'h1, 1'h1, 20); // monitor disables
    $display("test pattern done");
    close_out;
  end
endmodule
